// >>> src/acr_pkg.sv
// Package for the converter clock and rate selection block.
// Assumes a 32-bit classic Wishbone register bus and one 25 MHz system clock.
package acr_pkg;

  // Register byte addresses.
  localparam logic [7:0] ACR_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ACR_ADDR_STATUS = 8'h04;
  localparam logic [7:0] ACR_ADDR_DATA   = 8'h08;

  // Control register fields.
  localparam int ACR_CTRL_SRC_BIT  = 0;
  localparam int ACR_CTRL_PWR_LSB  = 1;
  localparam int ACR_CTRL_OSR_LSB  = 3;
  localparam int ACR_CTRL_STBY_BIT = 6;
  localparam int ACR_CTRL_W        = 7;

  // Status register fields.
  localparam int ACR_STAT_OSC_BIT = 0;
  localparam int ACR_STAT_NEW_BIT = 1;
  localparam int ACR_STAT_OVR_BIT = 2;

  // Reset values: external clock, high resolution, lowest ratio, running.
  localparam logic       ACR_RST_SRC  = 1'b0;
  localparam logic [1:0] ACR_RST_PWR  = 2'h2;
  localparam logic [2:0] ACR_RST_OSR  = 3'h0;
  localparam logic       ACR_RST_STBY = 1'b0;

  // Power mode field codes.
  localparam logic [1:0] ACR_PWR_VLP = 2'h0;
  localparam logic [1:0] ACR_PWR_LP  = 2'h1;

  // Oscillator divide ratios per power mode, minus one.
  localparam logic [1:0] ACR_DIV_HR  = 2'h0;
  localparam logic [1:0] ACR_DIV_LP  = 2'h1;
  localparam logic [1:0] ACR_DIV_VLP = 2'h3;

  // Smallest oversampling ratio; each field step doubles it.
  localparam logic [14:0] ACR_OSR_BASE = 15'h0080;

  // Width of the ratio and sample counters (ratio up to 16384).
  localparam int ACR_CNT_W = 15;

  // Nominal internal oscillator and system clock in kHz.
  localparam int ACR_OSC_KHZ = 8192;
  localparam int ACR_SYS_KHZ = 25000;
  localparam int ACR_OSC_DIV = ACR_SYS_KHZ / ACR_OSC_KHZ;

endpackage : acr_pkg

// >>> src/acr_clock_rate.sv
// Main clock selection, power-mode division, modulator clock and data rate.
// Assumes classic Wishbone on clk_sys and pins synchronous to clk_sys.
// Functional notes
// - Control source bit picks external clock input or internal oscillator.
// - After reset the external clock input is the main clock source.
// - Internal oscillator stays disabled until the source bit selects it.
// - Two-bit power mode field picks high-res, low-power or very-low-power.
// - Internal oscillator divided by 1, 2 or 4 by power mode.
// - Modulator clock is always main clock divided by two.
// - Output data rate is modulator clock divided by oversampling ratio.
// - Three-bit oversampling field picks ratios 128 through 16384.
// - Decimation averages the modulator bit-stream with a linear-phase sinc.
`timescale 1ns/100ps
module acr_clock_rate #(
  parameter int OSC_DIV = acr_pkg::ACR_OSC_DIV
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          external_clock_input,
  input  wire logic                          modBit,
  output logic                               oscEnable_r,
  output logic                               mainClkTick_r,
  output logic                               modulatorClkTick_r,
  output logic                               dataReady_r,
  output logic      [acr_pkg::ACR_CNT_W-1:0] sampleOut_r
);
  import acr_pkg::*;

  // Oscillator divide ratio minus one for a power mode code.
  function automatic logic [1:0] pwrDiv(input logic [1:0] pwr);
    unique case (pwr)
      ACR_PWR_VLP: pwrDiv = ACR_DIV_VLP;
      ACR_PWR_LP:  pwrDiv = ACR_DIV_LP;
      default:     pwrDiv = ACR_DIV_HR;
    endcase
  endfunction : pwrDiv

  // Oversampling ratio minus one for a field code.
  function automatic logic [ACR_CNT_W-1:0] osrLast(input logic [2:0] osr);
    osrLast = (ACR_OSR_BASE << osr) - 15'h0001;
  endfunction : osrLast

  localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);

  // Control and status state.
  logic                 clkSrcInt_r,  clkSrcInt_nxt;
  logic [1:0]           powerMode_r,  powerMode_nxt;
  logic [2:0]           osrSel_r,     osrSel_nxt;
  logic                 standby_r,    standby_nxt;
  logic                 newData_r,    newData_nxt;
  logic                 overrun_r,    overrun_nxt;
  logic                 ack_nxt;
  logic [31:0]          rdData_nxt;
  logic                 oscEnable_nxt;

  // Clock generation state.
  logic [7:0]           oscCnt_r,     oscCnt_nxt;
  logic [1:0]           mainDivCnt_r, mainDivCnt_nxt;
  logic                 extPrev_r,    extPrev_nxt;
  logic                 modPhase_r,   modPhase_nxt;
  logic                 mainTick_nxt;
  logic                 modTick_nxt;

  // Decimation state.
  logic [ACR_CNT_W-1:0] osrCnt_r,     osrCnt_nxt;
  logic [ACR_CNT_W-1:0] acc_r,        acc_nxt;
  logic [ACR_CNT_W-1:0] sample_nxt;
  logic                 ready_nxt;

  logic                 busReq;
  logic                 wrCtrl;
  logic                 rdData;
  logic                 oscTick;

  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrCtrl = busReq && wb_we_i && wb_sel_i[0]
                  && (wb_adr_i == ACR_ADDR_CTRL);
  assign rdData = busReq && !wb_we_i && (wb_adr_i == ACR_ADDR_DATA);

  // Register bus: one wait state, ack for every address, zero when unmapped.
  always_comb begin
    clkSrcInt_nxt = clkSrcInt_r;
    powerMode_nxt = powerMode_r;
    osrSel_nxt    = osrSel_r;
    standby_nxt   = standby_r;
    newData_nxt   = newData_r;
    overrun_nxt   = overrun_r;
    ack_nxt       = busReq;
    rdData_nxt    = wb_dat_o;
    if (wrCtrl) begin
      clkSrcInt_nxt = wb_dat_i[ACR_CTRL_SRC_BIT];
      powerMode_nxt = wb_dat_i[ACR_CTRL_PWR_LSB +: 2];
      osrSel_nxt    = wb_dat_i[ACR_CTRL_OSR_LSB +: 3];
      standby_nxt   = wb_dat_i[ACR_CTRL_STBY_BIT];
    end
    if (busReq && !wb_we_i) begin
      rdData_nxt = 32'h0000_0000;
      unique case (wb_adr_i)
        ACR_ADDR_CTRL: begin
          rdData_nxt[ACR_CTRL_SRC_BIT]      = clkSrcInt_r;
          rdData_nxt[ACR_CTRL_PWR_LSB +: 2] = powerMode_r;
          rdData_nxt[ACR_CTRL_OSR_LSB +: 3] = osrSel_r;
          rdData_nxt[ACR_CTRL_STBY_BIT]     = standby_r;
        end
        ACR_ADDR_STATUS: begin
          rdData_nxt[ACR_STAT_OSC_BIT] = oscEnable_r;
          rdData_nxt[ACR_STAT_NEW_BIT] = newData_r;
          rdData_nxt[ACR_STAT_OVR_BIT] = overrun_r;
        end
        ACR_ADDR_DATA: rdData_nxt[ACR_CNT_W-1:0] = sampleOut_r;
        default:       rdData_nxt = 32'h0000_0000;
      endcase
    end
    // Reading the data clears the flags; a new sample in that cycle wins.
    if (rdData) begin
      newData_nxt = 1'b0;
      overrun_nxt = 1'b0;
    end
    if (ready_nxt) begin
      overrun_nxt = overrun_nxt || (newData_r && !rdData);
      newData_nxt = 1'b1;
    end
    // Oscillator runs only while it is the selected source.
    oscEnable_nxt = clkSrcInt_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clkSrcInt_r <= ACR_RST_SRC;
      powerMode_r <= ACR_RST_PWR;
      osrSel_r    <= ACR_RST_OSR;
      standby_r   <= ACR_RST_STBY;
      newData_r   <= 1'b0;
      overrun_r   <= 1'b0;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      oscEnable_r <= 1'b0;
    end else begin
      clkSrcInt_r <= clkSrcInt_nxt;
      powerMode_r <= powerMode_nxt;
      osrSel_r    <= osrSel_nxt;
      standby_r   <= standby_nxt;
      newData_r   <= newData_nxt;
      overrun_r   <= overrun_nxt;
      wb_ack_o    <= ack_nxt;
      wb_dat_o    <= rdData_nxt;
      oscEnable_r <= oscEnable_nxt;
    end
  end

  // Internal oscillator modelled as an enable pulse divided from clk_sys.
  assign oscTick = oscEnable_r && (oscCnt_r == OSC_LAST);

  // Main and modulator clock enables. Standby holds the main divider and modulator
  // phase at rest, which is what makes a source or power mode change glitch free.
  always_comb begin
    oscCnt_nxt     = oscCnt_r;
    mainDivCnt_nxt = mainDivCnt_r;
    modPhase_nxt   = modPhase_r;
    mainTick_nxt   = 1'b0;
    modTick_nxt    = 1'b0;
    extPrev_nxt    = external_clock_input;
    if (oscEnable_r) begin
      oscCnt_nxt = oscTick ? 8'h00 : oscCnt_r + 8'h01;
    end else begin
      oscCnt_nxt = 8'h00;
    end
    if (standby_r) begin
      mainDivCnt_nxt = 2'h0;
      modPhase_nxt   = 1'b0;
    end else begin
      if (clkSrcInt_r) begin
        if (oscTick) begin
          if (mainDivCnt_r >= pwrDiv(powerMode_r)) begin
            mainDivCnt_nxt = 2'h0;
            mainTick_nxt   = 1'b1;
          end else begin
            mainDivCnt_nxt = mainDivCnt_r + 2'h1;
          end
        end
      end else begin
        mainDivCnt_nxt = 2'h0;
        mainTick_nxt   = external_clock_input && !extPrev_r;
      end
      if (mainTick_nxt) begin
        modPhase_nxt = !modPhase_r;
        modTick_nxt  = modPhase_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      oscCnt_r           <= 8'h00;
      mainDivCnt_r       <= 2'h0;
      extPrev_r          <= 1'b0;
      modPhase_r         <= 1'b0;
      mainClkTick_r      <= 1'b0;
      modulatorClkTick_r <= 1'b0;
    end else begin
      oscCnt_r           <= oscCnt_nxt;
      mainDivCnt_r       <= mainDivCnt_nxt;
      extPrev_r          <= extPrev_nxt;
      modPhase_r         <= modPhase_nxt;
      mainClkTick_r      <= mainTick_nxt;
      modulatorClkTick_r <= modTick_nxt;
    end
  end

  // Decimation: boxcar average of the bit-stream over one ratio window.
  always_comb begin
    osrCnt_nxt = osrCnt_r;
    acc_nxt    = acc_r;
    sample_nxt = sampleOut_r;
    ready_nxt  = 1'b0;
    if (standby_r) begin
      osrCnt_nxt = '0;
      acc_nxt    = '0;
    end else if (modulatorClkTick_r) begin
      if (osrCnt_r >= osrLast(osrSel_r)) begin
        osrCnt_nxt = '0;
        acc_nxt    = '0;
        sample_nxt = acc_r + ACR_CNT_W'(modBit);
        ready_nxt  = 1'b1;
      end else begin
        osrCnt_nxt = osrCnt_r + ACR_CNT_W'(1);
        acc_nxt    = acc_r + ACR_CNT_W'(modBit);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osrCnt_r    <= '0;
      acc_r       <= '0;
      sampleOut_r <= '0;
      dataReady_r <= 1'b0;
    end else begin
      osrCnt_r    <= osrCnt_nxt;
      acc_r       <= acc_nxt;
      sampleOut_r <= sample_nxt;
      dataReady_r <= ready_nxt;
    end
  end

endmodule : acr_clock_rate

// >>> dv/acr_clock_rate_asserts.sv
// Port checks for the clock and rate selection block.
// Assumes it is bound to acr_clock_rate with matching port names.
`timescale 1ns/100ps
module acr_clock_rate_asserts
  import acr_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [7:0]              wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic                    wb_ack_o,
  input wire logic                    oscEnable_r,
  input wire logic                    mainClkTick_r,
  input wire logic                    modulatorClkTick_r,
  input wire logic                    dataReady_r,
  input wire logic [ACR_CNT_W-1:0]    sampleOut_r
);
  logic        srcWr;
  logic [15:0] gapCnt_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  assign srcWr = wb_ack_o && wb_we_i && wb_adr_i == ACR_ADDR_CTRL
                 && wb_sel_i[0];
  // Cycles since the last sample, saturating.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) gapCnt_r <= 16'hFFFF;
    else if (dataReady_r) gapCnt_r <= 16'h0000;
    else if (gapCnt_r != 16'hFFFF) gapCnt_r <= gapCnt_r + 16'h0001;
  end
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_osc_cause: assert property ($changed(oscEnable_r)
    |-> srcWr || $past(srcWr)) else $error("osc enable moved");
  chk_reset_src: assert property ($rose(rst_b) |-> !oscEnable_r)
    else $error("osc enabled after reset");
  chk_mod_alone: assert property (modulatorClkTick_r
    |=> !modulatorClkTick_r) else $error("mod ticks adjacent");
  chk_mod_align: assert property (modulatorClkTick_r
    |-> mainClkTick_r || $past(mainClkTick_r)) else $error("mod stray");
  chk_data_gap: assert property (dataReady_r
    |-> gapCnt_r >= 16'h00FE) else $error("samples too close");
  chk_sample_max: assert property (dataReady_r
    |-> sampleOut_r <= 15'h4000) else $error("sample too big");
endmodule : acr_clock_rate_asserts

// >>> dv/acr_ext_src.sv
// External main clock source and modulator bit-stream for the bench.
// Assumes the modulator tick comes from the block under test.
`timescale 1ns/100ps
module acr_ext_src #(
  parameter int HALF = 3
) (
  input  wire logic clk_sys,
  input  wire logic modulatorClkTick_r,
  output logic      extClk,
  output logic      modBit
);
  int cnt = 0;
  initial begin
    extClk = 1'b0;
    modBit = 1'b0;
  end
  // The clock never pauses; the bit-stream alternates per modulator tick.
  always @(posedge clk_sys) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) extClk <= ~extClk;
    if (modulatorClkTick_r) modBit <= ~modBit;
  end
endmodule : acr_ext_src

// >>> dv/tb.sv
// Self-checking bench for the clock and rate selection block.
// Assumes a Wishbone register bus and the external source model.
`timescale 1ns/100ps
module tb;
  import acr_pkg::*;
  localparam int HALF = 3;
  localparam int OSC = 1;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0000_0000, wbDatO, rdData;
  logic extClk, modBit, oscEn, mTick, modTick, ready;
  logic [ACR_CNT_W-1:0] sample;
  int n_mismatch = 0, n_compared = 0, cycN = 0;
  int div[4] = '{4, 2, 1, 1};
  acr_clock_rate #(.OSC_DIV(OSC)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .external_clock_input(extClk), .modBit(modBit),
    .oscEnable_r(oscEn), .mainClkTick_r(mTick),
    .modulatorClkTick_r(modTick), .dataReady_r(ready), .sampleOut_r(sample));
  acr_ext_src #(.HALF(HALF)) u_src (.clk_sys(clk_sys),
    .modulatorClkTick_r(modTick), .extClk(extClk), .modBit(modBit));
  initial forever #20 clk_sys = ~clk_sys;
  function automatic logic [31:0] ctrl(logic s, logic [1:0] p,
                                       logic [2:0] o, logic sb);
    return {25'h0, sb, o, p, s};
  endfunction : ctrl
  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= w;
    wbAdr <= a; wbSel <= 4'hF; wbDatI <= d;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wbAck !== 1'b1 && t < 50);
    rdData = wbDatO;
    wbCyc <= 1'b0; wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  // Cycles between two consecutive main or modulator ticks.
  task automatic gap(input logic m, output int n);
    int t;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while ((m ? modTick : mTick) !== 1'b1 && t < 200);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((m ? modTick : mTick) !== 1'b1 && n < 200);
  endtask : gap
  always @(posedge clk_sys) begin
    cycN++;
    if (cycN == 90000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    int g;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk("osc idle", 32'h0, oscEn);
    bus(1'b0, ACR_ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000_0004, rdData);
    bus(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rdData);
    gap(1'b0, g);
    chk("ext gap", 2 * HALF, g);
    gap(1'b1, g);
    chk("ext mod gap", 4 * HALF, g);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, ACR_ADDR_CTRL, ctrl(1'b1, p[1:0], 3'h0, 1'b1));
      bus(1'b1, ACR_ADDR_CTRL, ctrl(1'b1, p[1:0], 3'h0, 1'b0));
      gap(1'b0, g);
      chk("osc gap", OSC * div[p], g);
      gap(1'b1, g);
      chk("osc mod gap", 2 * OSC * div[p], g);
    end
    bus(1'b0, ACR_ADDR_STATUS, 32'h0);
    chk("status osc", 32'h1, rdData[ACR_STAT_OSC_BIT]);
    for (int o = 0; o < 8; o++) begin
      bus(1'b1, ACR_ADDR_CTRL, ctrl(1'b1, 2'h2, o[2:0], 1'b1));
      bus(1'b1, ACR_ADDR_CTRL, ctrl(1'b1, 2'h2, o[2:0], 1'b0));
      g = 0;
      while (ready !== 1'b1 && g < (256 << o) + 64) begin
        @(posedge clk_sys);
        g++;
      end
      chk("sample", 64 << o, sample);
      bus(1'b0, ACR_ADDR_DATA, 32'h0);
      chk("data reg", 64 << o, rdData);
    end
    bus(1'b0, ACR_ADDR_STATUS, 32'h0);
    chk("status clr", 32'h0000_0001, rdData);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, ACR_ADDR_CTRL, 32'h0);
    chk("ctrl again", 32'h0000_0004, rdData);
    chk("osc again", 32'h0, oscEn);
    give_verdict();
  end
endmodule : tb
bind acr_clock_rate acr_clock_rate_asserts u_chk (.clk_sys, .rst_b,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_ack_o,
  .oscEnable_r, .mainClkTick_r, .modulatorClkTick_r, .dataReady_r,
  .sampleOut_r);
